// ---- hw/dso_pkg.sv ----
/*
 * Constants for the drive status output block: register map, reset values,
 * function codes and field layout.
 * Assumes frequencies are unsigned counts of 0.01 Hz on 16 bits.
 */
package dso_pkg;
   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_POLARITY = 8'h00;
   localparam logic [7:0] REG_FSEL_LO = 8'h04;
   localparam logic [7:0] REG_FSEL_HI = 8'h08;
   localparam logic [7:0] REG_THR_A = 8'h0C;
   localparam logic [7:0] REG_THR_B = 8'h10;
   localparam logic [7:0] REG_FMAX = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [7:0] REG_IRQ_STAT = 8'h1C;
   localparam logic [7:0] REG_IRQ_MASK = 8'h20;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] POL_RST_OUT = 2'h0;
   localparam logic [1:0] POL_RST_RELAY = 2'h1;
   localparam logic [7:0] FSEL_RST_OUT = 8'h00;
   localparam logic [7:0] FSEL_RST_RELAY = 8'h05;
   localparam logic [15:0] THR_RST = 16'h0000;
   localparam logic [15:0] FMAX_RST = 16'h1770;

   // ----------------------------------------------------------------
   // Function selector codes
   // ----------------------------------------------------------------
   localparam logic [7:0] FN_RUN = 8'h00;
   localparam logic [7:0] FN_CS_ARR = 8'h01;
   localparam logic [7:0] FN_EXC_A = 8'h02;
   localparam logic [7:0] FN_ALARM = 8'h05;
   localparam logic [7:0] FN_ONLY_A = 8'h06;
   localparam logic [7:0] FN_EXC_B = 8'h18;
   localparam logic [7:0] FN_ONLY_B = 8'h19;

   // ----------------------------------------------------------------
   // Hysteresis percentages and threshold range (0.01 Hz units)
   // ----------------------------------------------------------------
   localparam int HYST_ON_PCT = 1;
   localparam int HYST_OFF_PCT = 2;
   localparam logic [15:0] THR_FINE_LIMIT = 16'h2710;
   localparam logic [15:0] THR_MAX = 16'h9C40;
   localparam logic [15:0] THR_COARSE_STEP = 16'h000A;

   // Status bit positions of the indications
   localparam int IND_RUN = 0;
   localparam int IND_CS_ARR = 1;
   localparam int IND_EXC_A = 2;
   localparam int IND_ONLY_A = 3;
   localparam int IND_EXC_B = 4;
   localparam int IND_ONLY_B = 5;
   localparam int NUM_IND = 6;
endpackage : dso_pkg

// ---- hw/dso_top.sv ----
/*
 * Drive status output logic: running and frequency arrival indications,
 * per-terminal function selection and polarity, register port, interrupt.
 * Assumes all inputs come from the control core on clk_i; frequencies are
 * unsigned 0.01 Hz counts.
 */
// Notes on behaviour
// - Each transistor output has polarity: 00 follows signal, 01 inverts it.
// - Relay polarity 00 closes contact A, opens B; 01 opposite; default 01.
// - Each terminal has a function selector; 00 is running; relay defaults 05.
// - Running indication is also on during DC injection braking.
// - Running stays on while run command is on, even at 0 Hz.
// - After run command drops, running holds until the motor has stopped.
// - Codes 01, 02, 06, 24, 25 select the five arrival indications.
// - Arrival on at target minus 1% of max, off at target minus 2%.
// - Threshold-only in acceleration: on at thr-1%, off at thr+2%.
// - Threshold-only in deceleration: on at thr+1%, off at thr-2%.
// - Constant-speed arrival compares against main or multistep commanded frequency.
// - Exceeded indications compare against first and second threshold pairs.
// - Threshold zero suppresses that direction's indication; all default zero.
// - Threshold-only indications assert only in band around their threshold pair.
`timescale 1ns/100ps
module dso_top #(
   parameter int FQW = 16
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic forward_run_command_i,
   input wire logic dcb_active_i,
   input wire logic motor_stopped_i,
   input wire logic fault_i,
   input wire logic [FQW-1:0] out_freq_i,
   input wire logic [FQW-1:0] main_frequency_setting_i,
   input wire logic [FQW-1:0] multistep_speed_i,
   input wire logic multistep_active_i,
   output logic [4:0] transistor_out_o,
   output logic relay_contact_a_o,
   output logic relay_contact_b_o,
   output logic irq_o
);
   // Assertions below share the one clock and the synchronous reset
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [FQW-1:0] sat_sub(input logic [FQW-1:0] a, input logic [FQW-1:0] b);
      sat_sub = (a > b) ? a - b : '0;
   endfunction : sat_sub

   function automatic logic [FQW-1:0] sat_add(input logic [FQW-1:0] a, input logic [FQW-1:0] b);
      logic [FQW:0] s;
      s = {1'b0, a} + {1'b0, b};
      sat_add = s[FQW] ? '1 : s[FQW-1:0];
   endfunction : sat_add

   // Clamp to top and drop the hundredths digit above 100 Hz
   function automatic logic [15:0] legal_thr(input logic [15:0] v);
      logic [15:0] c;
      c = (v > dso_pkg::THR_MAX) ? dso_pkg::THR_MAX : v;
      legal_thr = (c >= dso_pkg::THR_FINE_LIMIT) ? c - (c % dso_pkg::THR_COARSE_STEP) : c;
   endfunction : legal_thr

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [1:0] pol_q [6];
   logic [7:0] fsel_q [6];
   logic [15:0] acc_thr_a_q, dec_thr_a_q, acc_thr_b_q, dec_thr_b_q;
   logic [15:0] fmax_q;
   logic [dso_pkg::NUM_IND-1:0] irq_stat_q, irq_mask_q;
   logic [dso_pkg::NUM_IND-1:0] ind_q, ind_prev_q;
   logic [4:0] tout_q;
   logic relay_q;
   logic wr_pol, wr_lo, wr_hi;
   assign wr_pol = wr_i && (addr_i == dso_pkg::REG_POLARITY);
   assign wr_lo = wr_i && (addr_i == dso_pkg::REG_FSEL_LO);
   assign wr_hi = wr_i && (addr_i == dso_pkg::REG_FSEL_HI);

   // Polarity and selectors; relay resets to its own codes
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < 5; i++) begin
            pol_q[i] <= dso_pkg::POL_RST_OUT;
            fsel_q[i] <= dso_pkg::FSEL_RST_OUT;
         end
         pol_q[5] <= dso_pkg::POL_RST_RELAY;
         fsel_q[5] <= dso_pkg::FSEL_RST_RELAY;
      end else begin
         if (wr_pol) begin
            for (int i = 0; i < 6; i++) begin
               pol_q[i] <= wdata_i[2*i +: 2];
            end
         end
         if (wr_lo) begin
            for (int i = 0; i < 4; i++) begin
               fsel_q[i] <= wdata_i[8*i +: 8];
            end
         end
         if (wr_hi) begin
            fsel_q[4] <= wdata_i[7:0];
            fsel_q[5] <= wdata_i[15:8];
         end
      end
   end

   // Thresholds and maximum frequency
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         acc_thr_a_q <= dso_pkg::THR_RST;
         dec_thr_a_q <= dso_pkg::THR_RST;
         acc_thr_b_q <= dso_pkg::THR_RST;
         dec_thr_b_q <= dso_pkg::THR_RST;
         fmax_q <= dso_pkg::FMAX_RST;
      end else if (wr_i) begin
         if (addr_i == dso_pkg::REG_THR_A) begin
            acc_thr_a_q <= legal_thr(wdata_i[15:0]);
            dec_thr_a_q <= legal_thr(wdata_i[31:16]);
         end
         if (addr_i == dso_pkg::REG_THR_B) begin
            acc_thr_b_q <= legal_thr(wdata_i[15:0]);
            dec_thr_b_q <= legal_thr(wdata_i[31:16]);
         end
         if (addr_i == dso_pkg::REG_FMAX) begin
            fmax_q <= wdata_i[15:0];
         end
      end
   end

   // Read data, one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i) begin
         case (addr_i)
            dso_pkg::REG_POLARITY: rdata_o <= {20'h00000, pol_q[5], pol_q[4], pol_q[3],
                                               pol_q[2], pol_q[1], pol_q[0]};
            dso_pkg::REG_FSEL_LO: rdata_o <= {fsel_q[3], fsel_q[2], fsel_q[1], fsel_q[0]};
            dso_pkg::REG_FSEL_HI: rdata_o <= {16'h0000, fsel_q[5], fsel_q[4]};
            dso_pkg::REG_THR_A: rdata_o <= {dec_thr_a_q, acc_thr_a_q};
            dso_pkg::REG_THR_B: rdata_o <= {dec_thr_b_q, acc_thr_b_q};
            dso_pkg::REG_FMAX: rdata_o <= {16'h0000, fmax_q};
            dso_pkg::REG_STATUS: rdata_o <= {18'h00000, relay_q, tout_q, 2'h0, ind_q};
            dso_pkg::REG_IRQ_STAT: rdata_o <= {26'h0000000, irq_stat_q};
            dso_pkg::REG_IRQ_MASK: rdata_o <= {26'h0000000, irq_mask_q};
            default: rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Running indication
   // ----------------------------------------------------------------
   logic stop_hold_q;
   logic running;

   // Hold past run removal until the motor reports standstill
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         stop_hold_q <= 1'b0;
      end else if (forward_run_command_i) begin
         stop_hold_q <= 1'b1;
      end else if (motor_stopped_i) begin
         stop_hold_q <= 1'b0;
      end
   end
   // Run command alone suffices, output frequency is not looked at
   assign running = forward_run_command_i || dcb_active_i || stop_hold_q;

   // ----------------------------------------------------------------
   // Frequency arrival comparators
   // ----------------------------------------------------------------
   logic [FQW-1:0] hys_on_q, hys_off_q, f_prev_q, target;
   logic accel_q;
   logic csa_q, exa_q, exb_q;
   logic ona, onb, exa_d, exb_d;

   // Offsets follow the configured maximum; registered to keep dividers off the path
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         hys_on_q <= '0;
         hys_off_q <= '0;
      end else begin
         hys_on_q <= FQW'((32'(fmax_q) * dso_pkg::HYST_ON_PCT) / 100);
         hys_off_q <= FQW'((32'(fmax_q) * dso_pkg::HYST_OFF_PCT) / 100);
      end
   end

   // Direction from last sample; held while frequency is steady
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         f_prev_q <= '0;
         accel_q <= 1'b1;
      end else begin
         f_prev_q <= out_freq_i;
         if (out_freq_i > f_prev_q) begin
            accel_q <= 1'b1;
         end else if (out_freq_i < f_prev_q) begin
            accel_q <= 1'b0;
         end
      end
   end

   assign target = multistep_active_i ? multistep_speed_i : main_frequency_setting_i;

   // Hysteresis latch: set at t-1%, cleared once fallen to t-2%
   function automatic logic hyst(input logic cur, input logic [FQW-1:0] f, input logic [FQW-1:0] t,
                                 input logic [FQW-1:0] on, input logic [FQW-1:0] off);
      if (f >= sat_sub(t, on)) begin
         hyst = 1'b1;
      end else if (f <= sat_sub(t, off)) begin
         hyst = 1'b0;
      end else begin
         hyst = cur;
      end
   endfunction : hyst

   // Band around a threshold, shape depends on direction
   function automatic logic band(input logic acc, input logic [FQW-1:0] f, input logic [FQW-1:0] t,
                                 input logic [FQW-1:0] on, input logic [FQW-1:0] off);
      if (acc) begin
         band = (f >= sat_sub(t, on)) && (f < sat_add(t, off));
      end else begin
         band = (f <= sat_add(t, on)) && (f > sat_sub(t, off));
      end
   endfunction : band

   logic [FQW-1:0] thr_a, thr_b;
   assign thr_a = accel_q ? acc_thr_a_q : dec_thr_a_q;
   assign thr_b = accel_q ? acc_thr_b_q : dec_thr_b_q;
   // Zero threshold in the present direction gives no indication
   assign exa_d = |thr_a && hyst(exa_q, out_freq_i, thr_a, hys_on_q, hys_off_q);
   assign exb_d = |thr_b && hyst(exb_q, out_freq_i, thr_b, hys_on_q, hys_off_q);
   assign ona = (thr_a != '0) && band(accel_q, out_freq_i, thr_a, hys_on_q, hys_off_q);
   assign onb = (thr_b != '0) && band(accel_q, out_freq_i, thr_b, hys_on_q, hys_off_q);

   // Latching indications
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         csa_q <= 1'b0;
         exa_q <= 1'b0;
         exb_q <= 1'b0;
      end else begin
         csa_q <= hyst(csa_q, out_freq_i, target, hys_on_q, hys_off_q);
         exa_q <= exa_d;
         exb_q <= exb_d;
      end
   end

   // ----------------------------------------------------------------
   // Selection, polarity and terminal outputs
   // ----------------------------------------------------------------
   logic [dso_pkg::NUM_IND-1:0] ind_d;
   always_comb begin
      ind_d = '0;
      ind_d[dso_pkg::IND_RUN] = running;
      ind_d[dso_pkg::IND_CS_ARR] = csa_q;
      ind_d[dso_pkg::IND_EXC_A] = exa_q;
      ind_d[dso_pkg::IND_ONLY_A] = ona;
      ind_d[dso_pkg::IND_EXC_B] = exb_q;
      ind_d[dso_pkg::IND_ONLY_B] = onb;
   end

   function automatic logic pick(input logic [7:0] code, input logic [dso_pkg::NUM_IND-1:0] ind,
                                 input logic flt);
      case (code)
         dso_pkg::FN_RUN: pick = ind[dso_pkg::IND_RUN];
         dso_pkg::FN_CS_ARR: pick = ind[dso_pkg::IND_CS_ARR];
         dso_pkg::FN_EXC_A: pick = ind[dso_pkg::IND_EXC_A];
         dso_pkg::FN_ALARM: pick = flt;
         dso_pkg::FN_ONLY_A: pick = ind[dso_pkg::IND_ONLY_A];
         dso_pkg::FN_EXC_B: pick = ind[dso_pkg::IND_EXC_B];
         dso_pkg::FN_ONLY_B: pick = ind[dso_pkg::IND_ONLY_B];
         default: pick = 1'b0;
      endcase
   endfunction : pick

   // Every terminal updates together from registered indications, or from fault_i for the alarm code
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         ind_q <= '0;
         tout_q <= 5'h00;
         relay_q <= 1'b0;
      end else begin
         ind_q <= ind_d;
         for (int i = 0; i < 5; i++) begin
            tout_q[i] <= pick(fsel_q[i], ind_q, fault_i) ^ pol_q[i][0];
         end
         relay_q <= pick(fsel_q[5], ind_q, fault_i) ^ pol_q[5][0];
      end
   end

   assign transistor_out_o = tout_q;
   assign relay_contact_a_o = relay_q;
   assign relay_contact_b_o = !relay_q;

   // ----------------------------------------------------------------
   // Interrupts: rising edge of any indication, write one to clear
   // ----------------------------------------------------------------
   logic [dso_pkg::NUM_IND-1:0] ev;
   assign ev = ind_q & ~ind_prev_q;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         ind_prev_q <= '0;
         irq_stat_q <= '0;
         irq_mask_q <= '0;
      end else begin
         ind_prev_q <= ind_q;
         // Set beats clear so an edge in the clearing cycle is kept
         if (wr_i && addr_i == dso_pkg::REG_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~wdata_i[dso_pkg::NUM_IND-1:0]) | ev;
         end else begin
            irq_stat_q <= irq_stat_q | ev;
         end
         if (wr_i && addr_i == dso_pkg::REG_IRQ_MASK) begin
            irq_mask_q <= wdata_i[dso_pkg::NUM_IND-1:0];
         end
      end
   end
   assign irq_o = |(irq_stat_q & irq_mask_q);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_out_pol;
      (fsel_q[0] == dso_pkg::FN_RUN && $stable(fsel_q[0]) && $stable(pol_q[0]))
         |=> (tout_q[0] == ($past(ind_q[dso_pkg::IND_RUN]) ^ $past(pol_q[0][0])));
   endproperty
   a_out_pol: assert property (p_out_pol) else $error("terminal 1 polarity wrong");
   // Relay carries the alarm through its polarity; the two contacts stay opposite
   property p_relay_pair;
      (fsel_q[5] == dso_pkg::FN_ALARM)
         |=> (relay_contact_a_o == ($past(fault_i) ^ $past(pol_q[5][0])))
            && (relay_contact_b_o != relay_contact_a_o);
   endproperty
   a_relay_pair: assert property (p_relay_pair) else $error("relay contacts wrong");
   property p_relay_rst;
      $rose(nrst_i) |-> (fsel_q[5] == dso_pkg::FN_ALARM && pol_q[5] == 2'h1);
   endproperty
   a_relay_rst: assert property (p_relay_rst) else $error("relay reset codes wrong");
   property p_dcb_run;
      dcb_active_i ##1 dcb_active_i |-> ind_q[dso_pkg::IND_RUN];
   endproperty
   a_dcb_run: assert property (p_dcb_run) else $error("no run during braking");
   property p_run_cmd;
      forward_run_command_i |=> ind_q[dso_pkg::IND_RUN];
   endproperty
   a_run_cmd: assert property (p_run_cmd) else $error("run missing with command on");
   property p_stop_hold;
      $fell(forward_run_command_i) && !motor_stopped_i |=> ind_q[dso_pkg::IND_RUN];
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("run dropped before stop");
   property p_stop_clear;
      (!forward_run_command_i && !dcb_active_i && motor_stopped_i) [*3]
         |-> !ind_q[dso_pkg::IND_RUN];
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("run held after stop");
   property p_arrive_on;
      (out_freq_i >= target) |=> csa_q;
   endproperty
   a_arrive_on: assert property (p_arrive_on) else $error("arrival missing");
   property p_thr_zero;
      (acc_thr_a_q == '0 && dec_thr_a_q == '0) |=> !exa_q;
   endproperty
   a_thr_zero: assert property (p_thr_zero) else $error("zero threshold not muting");
   property p_thr_range;
      acc_thr_a_q <= dso_pkg::THR_MAX &&
      (acc_thr_a_q < dso_pkg::THR_FINE_LIMIT || acc_thr_a_q % dso_pkg::THR_COARSE_STEP == 0);
   endproperty
   a_thr_range: assert property (p_thr_range) else $error("threshold out of range");
   property p_irq;
      (ev != '0) |=> ((irq_stat_q & $past(ev)) == $past(ev));
   endproperty
   a_irq: assert property (p_irq) else $error("event lost");

   c_run: cover property ($fell(ind_q[dso_pkg::IND_RUN]));
   c_arrive: cover property ($rose(csa_q));
   c_only_dec: cover property ($rose(ona) && !accel_q);
   c_irq: cover property ($rose(irq_o));
endmodule : dso_top

// ---- testbench/dso_core_model.sv ----
/*
 * Partner model of the drive control core: ramps the output frequency
 * toward a goal and reports standstill.
 * Assumes one clock, synchronous active-low reset, goals in steps of STEP.
 */
`timescale 1ns/100ps
module dso_core_model #(
   parameter int STEP = 10
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [15:0] goal_i,
   output logic [15:0] out_freq_o,
   output logic motor_stopped_o
);
   // ------------------------------------------------------------
   // Frequency ramp
   // ------------------------------------------------------------
   // Fixed step; goals must be multiples of STEP or the ramp hunts
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         out_freq_o <= 16'h0000;
      end else if (out_freq_o < goal_i) begin
         out_freq_o <= out_freq_o + 16'(STEP);
      end else if (out_freq_o > goal_i) begin
         out_freq_o <= out_freq_o - 16'(STEP);
      end
   end

   // Standstill only at exactly zero output
   assign motor_stopped_o = (out_freq_o == 16'h0000);
endmodule : dso_core_model

// ---- testbench/dso_top_tb.sv ----
/*
 * Self-checking bench for the drive status output block.
 * Assumes the core model drives output frequency and standstill; bench drives the rest.
 */
`timescale 1ns/100ps
module dso_top_tb;
   logic clk_i, nrst_i, wr_i, rd_i, run, dcb, fault, msa, stop, ra, rb, irq;
   logic [7:0] addr_i;
   logic [31:0] wdata_i, rdata_o;
   logic [15:0] freq, mfs, mss, goal;
   logic [4:0] tout;
   int fail_count, cmp_count;

   dso_core_model i_core (.clk_i(clk_i), .nrst_i(nrst_i), .goal_i(goal),
      .out_freq_o(freq), .motor_stopped_o(stop));

   dso_top i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .forward_run_command_i(run), .dcb_active_i(dcb),
      .motor_stopped_i(stop), .fault_i(fault), .out_freq_i(freq),
      .main_frequency_setting_i(mfs), .multistep_speed_i(mss),
      .multistep_active_i(msa), .transistor_out_o(tout),
      .relay_contact_a_o(ra), .relay_contact_b_o(rb), .irq_o(irq));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // Checks read values before the edge's updates land
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
   endtask : settle

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
      chk(n, e, rdata_o);
   endtask : rchk

   task automatic tc(input int b, input logic e);
      chk($sformatf("terminal%0d", b), {31'h0, e}, {31'h0, tout[b]});
   endtask : tc

   // Bounded wait; FA latches need three cycles after the last step
   task automatic ramp(input logic [15:0] g);
      int k;
      k = 0;
      @(posedge clk_i);
      goal <= g;
      while (freq !== g && k < 1000) begin
         @(posedge clk_i);
         k++;
      end
      chk("ramp", {16'h0, g}, {16'h0, freq});
      settle(5);
   endtask : ramp

   task automatic setrun(input logic v);
      @(posedge clk_i);
      run <= v;
      settle(4);
   endtask : setrun

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rchk(dso_pkg::REG_POLARITY, 32'h00000400, "polarity");
      rchk(dso_pkg::REG_FSEL_HI, 32'h00000500, "fsel_hi");
      rchk(dso_pkg::REG_THR_A, 32'h00000000, "thr_a");
      rchk(dso_pkg::REG_FMAX, 32'h00001770, "fmax");
      rchk(8'h24, 32'h00000000, "unmapped");
      chk("relay_a", 32'h1, {31'h0, ra});
      @(posedge clk_i);
      fault <= 1'b1;
      settle(4);
      chk("relay_a", 32'h0, {31'h0, ra});
      chk("relay_b", 32'h1, {31'h0, rb});
      @(posedge clk_i);
      fault <= 1'b0;
      $display("test reset done");
   endtask : t_reset

   task automatic t_run();
      setrun(1'b1);
      tc(0, 1'b1);
      ramp(16'h03E8);
      setrun(1'b0);
      tc(0, 1'b1);
      ramp(16'h0000);
      tc(0, 1'b0);
      @(posedge clk_i);
      dcb <= 1'b1;
      settle(4);
      tc(0, 1'b1);
      @(posedge clk_i);
      dcb <= 1'b0;
      settle(4);
      tc(0, 1'b0);
      wr(dso_pkg::REG_POLARITY, 32'h00000001);
      settle(4);
      tc(0, 1'b1);
      chk("relay_b", 32'h1, {31'h0, rb});
      wr(dso_pkg::REG_POLARITY, 32'h00000400);
      $display("test run and polarity done");
   endtask : t_run

   // Fmax 60.00 Hz: on 0.60 Hz, off 1.20 Hz below target
   task automatic t_arrive();
      wr(dso_pkg::REG_FSEL_LO, 32'h06020100);
      wr(dso_pkg::REG_FSEL_HI, 32'h00000518);
      mfs <= 16'h07D0;
      setrun(1'b1);
      ramp(16'h0794);
      tc(1, 1'b1);
      tc(2, 1'b0);
      ramp(16'h0762);
      tc(1, 1'b1);
      ramp(16'h0758);
      tc(1, 1'b0);
      ramp(16'h07D0);
      msa <= 1'b1;
      mss <= 16'h0BB8;
      settle(5);
      tc(1, 1'b0);
      msa <= 1'b0;
      settle(5);
      tc(1, 1'b1);
      wr(dso_pkg::REG_FMAX, 32'h00000BB8);
      settle(3);
      ramp(16'h078A);
      tc(1, 1'b0);
      $display("test constant speed done");
   endtask : t_arrive

   // Fmax 30.00 Hz: 1% is 0.30 Hz, 2% is 0.60 Hz; thresholds 10.00 Hz
   task automatic t_thr();
      wr(dso_pkg::REG_THR_A, 32'h000003E8);
      ramp(16'h0384);
      tc(2, 1'b0);
      ramp(16'h03E8);
      tc(2, 1'b1);
      tc(3, 1'b1);
      ramp(16'h0424);
      tc(3, 1'b0);
      wr(dso_pkg::REG_THR_A, 32'h03E803E8);
      ramp(16'h0410);
      tc(3, 1'b0);
      ramp(16'h0406);
      tc(3, 1'b1);
      ramp(16'h03AC);
      tc(3, 1'b0);
      tc(2, 1'b0);
      wr(dso_pkg::REG_THR_B, 32'h03E803E8);
      ramp(16'h03E8);
      tc(4, 1'b1);
      wr(dso_pkg::REG_FSEL_HI, 32'h00000519);
      settle(5);
      tc(4, 1'b1);
      ramp(16'h044C);
      tc(4, 1'b0);
      // Above the top clamps; above 100 Hz the hundredths digit drops
      wr(dso_pkg::REG_THR_A, 32'hFFFF2715);
      rchk(dso_pkg::REG_THR_A, 32'h9C402710, "thr_clamp");
      $display("test thresholds done");
   endtask : t_thr

   // Only the running bit is unmasked; arrival events stay silent
   task automatic t_irq();
      wr(dso_pkg::REG_IRQ_MASK, 32'h00000001);
      wr(dso_pkg::REG_IRQ_STAT, 32'h0000003F);
      settle(3);
      chk("irq", 32'h0, {31'h0, irq});
      setrun(1'b0);
      ramp(16'h0000);
      setrun(1'b1);
      chk("irq", 32'h1, {31'h0, irq});
      wr(dso_pkg::REG_IRQ_STAT, 32'h00000001);
      settle(3);
      chk("irq", 32'h0, {31'h0, irq});
      $display("test interrupt done");
   endtask : t_irq

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   // ------------------------------------------------------------
   // Clock, sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   initial begin
      {nrst_i, wr_i, rd_i, run, dcb, fault, msa} = '0;
      {addr_i, wdata_i, mfs, mss, goal} = '0;
      fail_count = 0;
      cmp_count = 0;
      settle(5);
      nrst_i <= 1'b1;
      t_reset();
      t_run();
      t_arrive();
      t_thr();
      t_irq();
      tally_and_finish();
   end

   // Tests take about 900 cycles; the 30000-cycle limit allows over thirty times that
   initial begin
      #300000;
      fail_count++;
      $display("watchdog expired");
      tally_and_finish();
   end
endmodule : dso_top_tb
